// ===== ddc_regs.svh
// ddc_regs.svh: field positions, codes, reset values and counts of the dual dac command block
// assumes inclusion by bare name; definitions only
`ifndef DDC_REGS_SVH
`define DDC_REGS_SVH
// ------------------------------------------------------------
// frame layout
// ------------------------------------------------------------
`define DDC_FRAME_BITS 32
`define DDC_CMD_MSB 27
`define DDC_CMD_LSB 24
`define DDC_ADDR_MSB 23
`define DDC_ADDR_LSB 20
`define DDC_DATA_MSB 19
`define DDC_DATA_LSB 4
`define DDC_PMODE_MSB 9
`define DDC_PMODE_LSB 8
// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define DDC_CMD_WR_INPUT 4'h0
`define DDC_CMD_WR_UPD_ONE 4'h3
`define DDC_CMD_WR_UPD_ALL 4'h2
`define DDC_CMD_UPD_FROM_IN 4'h1
`define DDC_CMD_POWER 4'h4
`define DDC_CMD_CLRSEL 4'h5
`define DDC_CMD_OVRMASK 4'h6
`define DDC_CMD_CHAIN 4'h8
// ------------------------------------------------------------
// address codes
// ------------------------------------------------------------
`define DDC_ADDR_A 4'h0
`define DDC_ADDR_B 4'h1
`define DDC_ADDR_ALL 4'hF
// ------------------------------------------------------------
// clear codes and reset values
// ------------------------------------------------------------
`define DDC_CLR_ZERO 16'h0000
`define DDC_CLR_MID 16'h8000
`define DDC_CLR_FULL 16'hFFFF
`define DDC_CLRSEL_RST 2'h0
`define DDC_CHAIN_RST 2'h0
`define DDC_CHAIN_ON 2'h2
`define DDC_PMODE_RST 2'h0
`define DDC_OVR_RST 4'h0
`define DDC_CODE_RST 16'h0000
`endif

// ===== ddc_pkg.sv
// ddc_pkg.sv: types shared by the dual dac command block
// assumes ddc_regs.svh on the include path
package ddc_pkg;
	// power mode of one channel
	typedef enum logic [1:0] {
		DDC_PM_NORMAL = 2'h0,
		DDC_PM_1K = 2'h1,
		DDC_PM_100K = 2'h2,
		DDC_PM_TRI = 2'h3
	} ddc_pmode_t;
	// one decoded frame handed across to the core domain
	typedef struct packed {
		logic [3:0] cmd;
		logic [3:0] addr;
		logic [15:0] data;
		logic [3:0] low_bits;
		logic [1:0] pmode;
	} ddc_frame_t;
	// per-channel analog-side view
	typedef struct packed {
		logic [15:0] code;
		logic powered_down;
		logic pull_1k;
		logic pull_100k;
		logic tristate;
	} ddc_chan_out_t;
endpackage : ddc_pkg

// ===== ddc_sync3.sv
// ddc_sync3.sv: three-stage synchroniser with agreement filter
// assumes asynchronous input, core clock and enable
`timescale 1ns/1ps
module ddc_sync3 (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_async,
	input wire logic i_rst_val,
	output logic o_level
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	// ------------------------------------------------------------
	// chain; stage one read by stage two only
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
		end else if (i_ce) begin
			s1_reg <= i_async;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	// filtered level, changes when stages two and three agree
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_level <= 1'b1;
		end else if (i_ce && (s2_reg == s3_reg)) begin
			o_level <= s2_reg;
		end
	end
	logic unused_rst_val;
	assign unused_rst_val = i_rst_val;
endmodule : ddc_sync3

// ===== ddc_shift_link.sv
// ddc_shift_link.sv: serial-clock side, 32-bit shift register, frame hand-off by toggle
// assumes link clock is the serial clock, gated outside frames; frame select active low
`timescale 1ns/1ps
module ddc_shift_link
	import ddc_pkg::*;
(
	input wire logic i_sclk,
	input wire logic i_rst_n,
	input wire logic i_frame_n,
	input wire logic i_sdi,
	input wire logic i_abort_tgl,
	input wire logic [1:0] i_chain_mode,
	output logic o_serial_out,
	output logic o_frame_tgl,
	output ddc_frame_t o_frame
);
`include "ddc_regs.svh"
	logic [31:0] sr_reg;
	logic [5:0] cnt_reg;
	logic ab_s1_reg;
	logic ab_s2_reg;
	logic ab_seen_reg;
	logic [31:0] sr_next;
	logic abort_now;
	logic done_now;
	// abort toggle from core crossed on falling serial edge
	always_ff @(negedge i_sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ab_s1_reg <= 1'b0;
			ab_s2_reg <= 1'b0;
		end else begin
			ab_s1_reg <= i_abort_tgl;
			ab_s2_reg <= ab_s1_reg;
		end
	end
	assign abort_now = (ab_s2_reg != ab_seen_reg);
	assign sr_next = {sr_reg[30:0], i_sdi};
	assign done_now = (cnt_reg == 6'(`DDC_FRAME_BITS - 1)) && !abort_now;
	// ------------------------------------------------------------
	// shifting; frame select high clears the count asynchronously
	// ------------------------------------------------------------
	always_ff @(negedge i_sclk or posedge i_frame_n) begin
		if (i_frame_n) begin
			cnt_reg <= 6'h00;
		end else if (abort_now) begin
			cnt_reg <= 6'h3F;
		end else if (cnt_reg != 6'h3F && cnt_reg != 6'(`DDC_FRAME_BITS)) begin
			cnt_reg <= cnt_reg + 6'h01;
		end
	end
	// abort acknowledged once seen
	always_ff @(negedge i_sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ab_seen_reg <= 1'b0;
		end else begin
			ab_seen_reg <= ab_s2_reg;
		end
	end
	// data shift, msb first
	always_ff @(negedge i_sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sr_reg <= 32'h0000_0000;
		end else if (!i_frame_n) begin
			sr_reg <= sr_next;
		end
	end
	// captured frame and hand-off toggle at the 32nd falling edge
	always_ff @(negedge i_sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_frame <= '0;
			o_frame_tgl <= 1'b0;
		end else if (!i_frame_n && done_now) begin
			o_frame.cmd <= sr_next[`DDC_CMD_MSB:`DDC_CMD_LSB];
			o_frame.addr <= sr_next[`DDC_ADDR_MSB:`DDC_ADDR_LSB];
			o_frame.data <= sr_next[`DDC_DATA_MSB:`DDC_DATA_LSB];
			o_frame.low_bits <= sr_next[3:0];
			o_frame.pmode <= sr_next[`DDC_PMODE_MSB:`DDC_PMODE_LSB];
			o_frame_tgl <= ~o_frame_tgl;
		end
	end
	// chained output launched on rising edge
	always_ff @(posedge i_sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_serial_out <= 1'b0;
		end else begin
			o_serial_out <= (i_chain_mode == `DDC_CHAIN_ON) ? sr_reg[31] : 1'b0;
		end
	end
endmodule : ddc_shift_link

// ===== ddc_core.sv
// ddc_core.sv: dual dac command decode, clear and load update control
// assumes serial clock on i_sclk (link domain), core clock 200 MHz, pins asynchronous
// Operation
// - frames are 32 bits msb first: pad, command, address, payload; act at 32nd edge
// - frame select rising before 32nd edge discards the frame, nothing changes
// - command 1000 loads chain mode from bits 1..0
// - chain mode defaults standalone; 10 forwards overflow bits to serial output
// - command 0100 applies power mode bits 9..8 to selected channels
// - power mode 00 normal, 01 1k, 10 100k, 11 tristate
// - clear acts on its falling edge only, asynchronous to serial clock
// - clear overwrites input and dac registers of both channels
// - clear select 00 zero, 01 mid, 10 full, 11 no clear
// - clear select resets to zero scale
// - command 0101 loads clear select from bits 1..0
// - cleared state ends at the 32nd edge of the next full frame
// - clear during a frame aborts that frame
// - with strobe low, new data reaches dac registers at 32nd edge
// - strobe falling edge copies input to dac for strobe-controlled channels
// - command 0010 writes input register then updates all dac registers
// - override mask bit set updates that channel as if strobe tied low
// - command 0110 loads override mask bits 3..0, bit1 b, bit0 a
// - override mask resets to zero
`timescale 1ns/1ps
module ddc_core
	import ddc_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_sclk,
	input wire logic i_frame_n,
	input wire logic i_sdi,
	input wire logic i_async_clear_n,
	input wire logic i_load_update_strobe_n,
	output logic o_serial_out,
	output ddc_chan_out_t o_chan_a,
	output ddc_chan_out_t o_chan_b,
	output logic o_cleared,
	output logic [1:0] o_chain_mode_enable
);
`include "ddc_regs.svh"
	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_s1_reg;
	logic rst_n_reg;
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_s1_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_reg <= rst_s1_reg;
		end
	end
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic clr_lvl;
	logic ld_lvl;
	logic clr_prev_reg;
	logic ld_prev_reg;
	logic clr_fall;
	logic ld_fall;
	logic frm_lvl;
	ddc_sync3 u_sync_clr (
		.i_core_clk(i_core_clk),
		.i_rst_n(rst_n_reg),
		.i_ce(i_ce),
		.i_async(i_async_clear_n),
		.i_rst_val(1'b1),
		.o_level(clr_lvl)
	);
	ddc_sync3 u_sync_ld (
		.i_core_clk(i_core_clk),
		.i_rst_n(rst_n_reg),
		.i_ce(i_ce),
		.i_async(i_load_update_strobe_n),
		.i_rst_val(1'b1),
		.o_level(ld_lvl)
	);
	ddc_sync3 u_sync_frm ( // frame select seen in the core domain
		.i_core_clk(i_core_clk),
		.i_rst_n(rst_n_reg),
		.i_ce(i_ce),
		.i_async(i_frame_n),
		.i_rst_val(1'b1),
		.o_level(frm_lvl)
	);
	// edge detectors on filtered levels
	always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			clr_prev_reg <= 1'b1;
			ld_prev_reg <= 1'b1;
		end else if (i_ce) begin
			clr_prev_reg <= clr_lvl;
			ld_prev_reg <= ld_lvl;
		end
	end
	assign clr_fall = i_ce && clr_prev_reg && !clr_lvl;
	assign ld_fall = i_ce && ld_prev_reg && !ld_lvl;
	// ------------------------------------------------------------
	// link side and frame crossing
	// ------------------------------------------------------------
	logic abort_tgl_reg;
	logic frame_tgl;
	ddc_frame_t frame_link;
	logic [1:0] chain_reg;
	logic [1:0] chain_s1_reg;
	logic [1:0] chain_s2_reg;
	logic [2:0] ftg_reg;
	logic frame_new;
	ddc_shift_link u_link (
		.i_sclk(i_sclk),
		.i_rst_n(rst_n_reg),
		.i_frame_n(i_frame_n),
		.i_sdi(i_sdi),
		.i_abort_tgl(abort_tgl_reg),
		.i_chain_mode(chain_s2_reg),
		.o_serial_out(o_serial_out),
		.o_frame_tgl(frame_tgl),
		.o_frame(frame_link)
	);
	// chain mode is quasi-static; two stages into the link domain
	always_ff @(posedge i_sclk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			chain_s1_reg <= `DDC_CHAIN_RST;
			chain_s2_reg <= `DDC_CHAIN_RST;
		end else begin
			chain_s1_reg <= chain_reg;
			chain_s2_reg <= chain_s1_reg;
		end
	end
	// frame toggle crossed in; frame word stable for many core cycles
	always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ftg_reg <= 3'h0;
		end else if (i_ce) begin
			ftg_reg <= {ftg_reg[1:0], frame_tgl};
		end
	end
	assign frame_new = i_ce && (ftg_reg[2] != ftg_reg[1]);
	// clear aborts only a frame in progress; idle link clock would carry it into the next frame
	always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			abort_tgl_reg <= 1'b0;
		end else if (clr_fall && !frm_lvl) begin
			abort_tgl_reg <= ~abort_tgl_reg;
		end
	end
	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic [1:0] sel_ch;
	logic is_write;
	logic upd_all;
	logic upd_addr;
	logic is_upd_only;
	logic clr_do;
	logic [15:0] clr_code;
	logic [1:0] clrsel_reg;
	logic [3:0] ovr_reg;
	always_comb begin
		sel_ch = 2'b00;
		unique case (frame_link.addr)
			`DDC_ADDR_A: sel_ch = 2'b01;
			`DDC_ADDR_B: sel_ch = 2'b10;
			`DDC_ADDR_ALL: sel_ch = 2'b11;
			default: sel_ch = 2'b00;
		endcase
	end
	assign is_write = (frame_link.cmd == `DDC_CMD_WR_INPUT) || (frame_link.cmd == `DDC_CMD_WR_UPD_ALL)
		|| (frame_link.cmd == `DDC_CMD_WR_UPD_ONE);
	assign upd_all = (frame_link.cmd == `DDC_CMD_WR_UPD_ALL);
	assign upd_addr = (frame_link.cmd == `DDC_CMD_WR_UPD_ONE);
	assign is_upd_only = (frame_link.cmd == `DDC_CMD_UPD_FROM_IN);
	// clear code selection
	always_comb begin
		clr_code = `DDC_CLR_ZERO;
		clr_do = 1'b1;
		unique case (clrsel_reg)
			2'h0: clr_code = `DDC_CLR_ZERO;
			2'h1: clr_code = `DDC_CLR_MID;
			2'h2: clr_code = `DDC_CLR_FULL;
			2'h3: clr_do = 1'b0;
		endcase
	end
	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			chain_reg <= `DDC_CHAIN_RST;
		end else if (frame_new && frame_link.cmd == `DDC_CMD_CHAIN) begin
			chain_reg <= frame_link.low_bits[1:0];
		end
	end
	always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			clrsel_reg <= `DDC_CLRSEL_RST;
		end else if (frame_new && frame_link.cmd == `DDC_CMD_CLRSEL) begin
			clrsel_reg <= frame_link.low_bits[1:0];
		end
	end
	always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ovr_reg <= `DDC_OVR_RST;
		end else if (frame_new && frame_link.cmd == `DDC_CMD_OVRMASK) begin
			ovr_reg <= frame_link.low_bits;
		end
	end
	// cleared state flag; a new clear wins over the exit
	always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			o_cleared <= 1'b0;
		end else if (clr_fall && clr_do) begin
			o_cleared <= 1'b1;
		end else if (frame_new) begin
			o_cleared <= 1'b0;
		end
	end
	assign o_chain_mode_enable = chain_reg;
	// ------------------------------------------------------------
	// per-channel input, dac and power registers
	// ------------------------------------------------------------
	logic [15:0] in_reg [2];
	logic [15:0] dac_reg [2];
	ddc_pmode_t pm_reg [2];
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			logic wr_hit;
			logic sync_upd;
			assign wr_hit = frame_new && is_write && sel_ch[g];
			// strobe low, override bit or update command takes new data at once
			assign sync_upd = wr_hit && (!ld_lvl || ovr_reg[g] || upd_addr);
			always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
				if (!rst_n_reg) begin
					in_reg[g] <= `DDC_CODE_RST;
				end else if (clr_fall && clr_do) begin
					in_reg[g] <= clr_code;
				end else if (wr_hit) begin
					in_reg[g] <= frame_link.data;
				end
			end
			always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
				if (!rst_n_reg) begin
					dac_reg[g] <= `DDC_CODE_RST;
				end else if (clr_fall && clr_do) begin
					dac_reg[g] <= clr_code;
				end else if (sync_upd) begin
					dac_reg[g] <= frame_link.data;
				end else if (frame_new && upd_all) begin
					dac_reg[g] <= wr_hit ? frame_link.data : in_reg[g];
				end else if (frame_new && is_upd_only && sel_ch[g]) begin
					dac_reg[g] <= in_reg[g];
				end else if (ld_fall && !ovr_reg[g]) begin
					dac_reg[g] <= in_reg[g];
				end
			end
			always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
				if (!rst_n_reg) begin
					pm_reg[g] <= ddc_pmode_t'(`DDC_PMODE_RST);
				end else if (frame_new && frame_link.cmd == `DDC_CMD_POWER && frame_link.low_bits[g]) begin
					pm_reg[g] <= ddc_pmode_t'(frame_link.pmode);
				end
			end
		end
	endgenerate
	// ------------------------------------------------------------
	// analog-side outputs
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			o_chan_a <= '0;
			o_chan_b <= '0;
		end else if (i_ce) begin
			o_chan_a <= {dac_reg[0], pm_reg[0] != DDC_PM_NORMAL, pm_reg[0] == DDC_PM_1K,
				pm_reg[0] == DDC_PM_100K, pm_reg[0] == DDC_PM_TRI};
			o_chan_b <= {dac_reg[1], pm_reg[1] != DDC_PM_NORMAL, pm_reg[1] == DDC_PM_1K,
				pm_reg[1] == DDC_PM_100K, pm_reg[1] == DDC_PM_TRI};
		end
	end
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_clr_load;
		@(posedge i_core_clk) disable iff (!rst_n_reg)
		(clr_fall && clr_do) |=> (dac_reg[0] == $past(clr_code) && in_reg[1] == $past(clr_code));
	endproperty
	a_clr_load: assert property (p_clr_load) else $error("clear did not load code");
	property p_clr_nop;
		@(posedge i_core_clk) disable iff (!rst_n_reg)
		(clr_fall && clrsel_reg == 2'h3 && !frame_new && !ld_fall) |=> $stable(in_reg[0]);
	endproperty
	a_clr_nop: assert property (p_clr_nop) else $error("clear select 11 changed data");
	property p_clr_mid;
		@(posedge i_core_clk) disable iff (!rst_n_reg)
		(clr_fall && clrsel_reg == 2'h1) |=> (in_reg[0] == 16'h8000 && dac_reg[1] == 16'h8000);
	endproperty
	a_clr_mid: assert property (p_clr_mid) else $error("mid code wrong");
	property p_ovr_load;
		@(posedge i_core_clk) disable iff (!rst_n_reg)
		(frame_new && frame_link.cmd == 4'h6) |=> (ovr_reg == $past(frame_link.low_bits));
	endproperty
	a_ovr_load: assert property (p_ovr_load) else $error("mask not loaded");
	property p_power_keep;
		@(posedge i_core_clk) disable iff (!rst_n_reg)
		(frame_new && frame_link.cmd == 4'h4 && !frame_link.low_bits[1]) |=> $stable(pm_reg[1]);
	endproperty
	a_power_keep: assert property (p_power_keep) else $error("unselected channel changed");
	property p_power_set;
		@(posedge i_core_clk) disable iff (!rst_n_reg)
		(frame_new && frame_link.cmd == 4'h4 && frame_link.low_bits[0]) |=> (pm_reg[0] == $past(frame_link.pmode));
	endproperty
	a_power_set: assert property (p_power_set) else $error("power mode not applied");
	property p_ld_fall;
		@(posedge i_core_clk) disable iff (!rst_n_reg)
		(ld_fall && !ovr_reg[0] && !clr_fall && !frame_new) |=> (dac_reg[0] == $past(in_reg[0]));
	endproperty
	a_ld_fall: assert property (p_ld_fall) else $error("strobe did not update");
	property p_exit_clear;
		@(posedge i_core_clk) disable iff (!rst_n_reg)
		(frame_new && !clr_fall) |=> !o_cleared;
	endproperty
	a_exit_clear: assert property (p_exit_clear) else $error("cleared state not left");
	property p_chain;
		@(posedge i_core_clk) disable iff (!rst_n_reg)
		(frame_new && frame_link.cmd == 4'h8) |=> (chain_reg == $past(frame_link.low_bits[1:0]));
	endproperty
	a_chain: assert property (p_chain) else $error("chain mode not loaded");
endmodule : ddc_core

// ===== ddc_host_model.sv
// ddc_host_model.sv: host serial port that sends frames to the dual dac block
// assumes the block takes data on falling clock edges, clock idle high
`timescale 1ns/1ps
module ddc_host_model (
	output logic o_sclk,
	output logic o_frame_n,
	output logic o_sdi
);
	// one falling edge during reset, then the clock stands still
	initial begin
		o_sclk = 1'b1;
		o_frame_n = 1'b1;
		o_sdi = 1'b0;
		#6 o_sclk = 1'b0;
		#6 o_sclk = 1'b1;
	end
	// msb first, nbits falling edges while frame select is low
	task automatic send(input logic [31:0] w, input int nbits);
		o_frame_n = 1'b0;
		for (int i = 31; i > 31 - nbits; i--) begin
			o_sdi = w[i];
			#6 o_sclk = 1'b0;
			#6 o_sclk = 1'b1;
		end
		#6 o_frame_n = 1'b1;
		o_sdi = ~o_sdi; // released line shows no stale bit
		#24;
	endtask : send
endmodule : ddc_host_model

// ===== dual_dac_command_control_tb.sv
// dual_dac_command_control_tb.sv: self-checking bench for the dual dac command block
// assumes ddc_core as top, host model on the serial side, pins driven here
`timescale 1ns/1ps
`include "ddc_regs.svh"
module dual_dac_command_control_tb import ddc_pkg::*; ;
	logic i_core_clk;
	logic i_rst_n;
	logic i_async_clear_n;
	logic i_load_update_strobe_n;
	logic i_ce;
	logic sclk, frame_n, sdi, serial_out, cleared;
	logic [1:0] chain;
	ddc_chan_out_t chan_a, chan_b;
	int miscompares = 0;
	int check_count = 0;
	logic [15:0] ctab [3] = '{16'h0000, 16'h8000, 16'hFFFF};
	logic [15:0] ea;

	ddc_host_model u_host (.o_sclk(sclk), .o_frame_n(frame_n), .o_sdi(sdi));
	ddc_core u_dut (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
		.i_sclk(sclk), .i_frame_n(frame_n), .i_sdi(sdi),
		.i_async_clear_n(i_async_clear_n), .i_load_update_strobe_n(i_load_update_strobe_n),
		.o_serial_out(serial_out), .o_chan_a(chan_a), .o_chan_b(chan_b),
		.o_cleared(cleared), .o_chain_mode_enable(chain)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	initial begin
		i_core_clk = 1'b0;
		forever #2.5 i_core_clk = ~i_core_clk;
	end
	task automatic conclude();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask : cyc
	task automatic frame(input logic [3:0] c, input logic [3:0] a, input logic [19:0] p);
		u_host.send({4'h0, c, a, p}, 32);
		cyc(12);
	endtask : frame
	task automatic strobe_pulse();
		i_load_update_strobe_n = 1'b0;
		cyc(10);
		i_load_update_strobe_n = 1'b1;
		cyc(10);
	endtask : strobe_pulse
	task automatic clear_pulse();
		i_async_clear_n = 1'b0;
		cyc(10);
		i_async_clear_n = 1'b1;
		cyc(10);
	endtask : clear_pulse
	function automatic logic [19:0] co(input logic [15:0] code, input logic [1:0] pm);
		return {code, pm != 2'h0, pm == 2'h1, pm == 2'h2, pm == 2'h3};
	endfunction : co

	// watchdog cuts a hang short
	initial begin
		#100us;
		miscompares++;
		conclude();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		i_rst_n = 1'b0;
		i_ce = 1'b1;
		i_async_clear_n = 1'b1;
		i_load_update_strobe_n = 1'b1;
		repeat (5) @(negedge i_core_clk);
		i_rst_n = 1'b1;
		cyc(12);
		check("chain", 32'(chain), 32'(`DDC_CHAIN_RST));
		// strobe-controlled write waits for the strobe edge
		frame(`DDC_CMD_WR_INPUT, `DDC_ADDR_A, {16'h1234, 4'h0});
		check("chan_a", 32'(chan_a), 32'(co(16'h0000, 2'h0)));
		strobe_pulse();
		check("chan_a", 32'(chan_a), 32'(co(16'h1234, 2'h0)));
		frame(`DDC_CMD_WR_UPD_ALL, `DDC_ADDR_B, {16'h5A5A, 4'h0});
		clear_pulse();
		check("chan_b", 32'(chan_b), 32'(co(16'h0000, 2'h0)));
		// every clear select, software strobe before each clear
		for (int s = 0; s < 4; s++) begin
			frame(`DDC_CMD_CLRSEL, `DDC_ADDR_A, 20'(s));
			frame(`DDC_CMD_WR_INPUT, `DDC_ADDR_A, {16'h1234, 4'h0});
			check("cleared", 32'(cleared), 32'h0);
			frame(`DDC_CMD_WR_UPD_ALL, `DDC_ADDR_B, {16'h5A5A, 4'h0});
			check("chan_a", 32'(chan_a), 32'(co(16'h1234, 2'h0)));
			clear_pulse();
			ea = (s == 3) ? 16'h1234 : ctab[s];
			check("chan_a", 32'(chan_a), 32'(co(ea, 2'h0)));
			check("chan_b", 32'(chan_b), 32'(co((s == 3) ? 16'h5A5A : ea, 2'h0)));
			check("cleared", 32'(cleared), 32'(s != 3));
		end
		// strobe held low updates at the frame end
		i_load_update_strobe_n = 1'b0;
		cyc(10);
		frame(`DDC_CMD_WR_INPUT, `DDC_ADDR_A, {16'hCAFE, 4'h0});
		check("chan_a", 32'(chan_a), 32'(co(16'hCAFE, 2'h0)));
		i_load_update_strobe_n = 1'b1;
		cyc(10);
		// override mask on channel b only
		frame(`DDC_CMD_OVRMASK, `DDC_ADDR_A, 20'h00002);
		frame(`DDC_CMD_WR_INPUT, `DDC_ADDR_ALL, {16'h7777, 4'h0});
		check("chan_b", 32'(chan_b), 32'(co(16'h7777, 2'h0)));
		check("chan_a", 32'(chan_a), 32'(co(16'hCAFE, 2'h0)));
		strobe_pulse();
		check("chan_a", 32'(chan_a), 32'(co(16'h7777, 2'h0)));
		// clear in mid-frame aborts the write, held low level does not repeat
		frame(`DDC_CMD_CLRSEL, `DDC_ADDR_A, 20'h00002);
		fork
			u_host.send({4'h0, `DDC_CMD_WR_UPD_ALL, `DDC_ADDR_B, 16'h1111, 4'h0}, 32);
			begin
				#120;
				@(negedge i_core_clk);
				i_async_clear_n = 1'b0;
			end
		join
		cyc(12);
		check("chan_b", 32'(chan_b), 32'(co(16'hFFFF, 2'h0)));
		frame(`DDC_CMD_WR_UPD_ALL, `DDC_ADDR_B, {16'h0F0F, 4'h0});
		check("chan_b", 32'(chan_b), 32'(co(16'h0F0F, 2'h0)));
		check("cleared", 32'(cleared), 32'h0);
		i_async_clear_n = 1'b1;
		cyc(10);
		// power modes on a with b untouched, then b to 1k, then both back to normal
		for (int m = 1; m < 4; m++) begin
			frame(`DDC_CMD_POWER, `DDC_ADDR_B, {10'h000, 2'(m), 6'h00, 2'h1});
			check("chan_a", 32'(chan_a), 32'(co(16'hFFFF, 2'(m))));
			check("chan_b", 32'(chan_b), 32'(co(16'h0F0F, 2'h0)));
		end
		frame(`DDC_CMD_POWER, `DDC_ADDR_A, {10'h000, 2'h1, 6'h00, 2'h2});
		check("chan_b", 32'(chan_b), 32'(co(16'h0F0F, 2'h1)));
		frame(`DDC_CMD_POWER, `DDC_ADDR_A, {10'h000, 2'h0, 6'h00, 2'h3});
		check("chan_a", 32'(chan_a), 32'(co(16'hFFFF, 2'h0)));
		// enable low freezes the core, so a clear pulse is missed
		i_ce = 1'b0;
		clear_pulse();
		i_ce = 1'b1;
		cyc(4);
		check("cleared", 32'(cleared), 32'h0);
		check("chan_b", 32'(chan_b), 32'(co(16'h0F0F, 2'h0)));
		// short frame is discarded, full one sets chain mode
		u_host.send({4'h0, `DDC_CMD_CHAIN, 4'h0, 20'h00002}, 31);
		cyc(12);
		check("chain", 32'(chain), 32'(`DDC_CHAIN_RST));
		// pad bits set; standalone keeps the serial output low
		u_host.send({4'h8, `DDC_CMD_CLRSEL, `DDC_ADDR_A, 20'h00002}, 32);
		cyc(12);
		check("serial_out", 32'(serial_out), 32'h0);
		frame(`DDC_CMD_CHAIN, `DDC_ADDR_B, 20'h00002);
		check("chain", 32'(chain), 32'(`DDC_CHAIN_ON));
		// chained output shows the bit shifted in 32 edges earlier
		u_host.send({4'h8, `DDC_CMD_CLRSEL, `DDC_ADDR_A, 20'h00002}, 32);
		cyc(12);
		check("serial_out", 32'(serial_out), 32'h1);
		conclude();
	end
endmodule : dual_dac_command_control_tb
